// [logic/rbp_pkg.sv]
// Package for the asynchronous parallel register port
package rbp_pkg;
  localparam int unsigned RBP_ADDR_W = 4;
  localparam int unsigned RBP_DATA_W = 8;
  localparam int unsigned RBP_NUM_REGS = 16;
  localparam logic [7:0] RBP_REG_RESET = 8'h00;
  localparam int unsigned RBP_SYNC_STAGES = 2;

  // Synchronised host strobes and buses
  typedef struct packed {
    logic cs_n;
    logic oe_n;
    logic we_n;
    logic [RBP_ADDR_W-1:0] addr;
    logic [RBP_DATA_W-1:0] data;
  } rbp_bus_t;

  // Port phase
  typedef enum logic [1:0] {
    RBP_IDLE,
    RBP_READ,
    RBP_WRITE,
    RBP_BLOCKED
  } rbp_state_t;
endpackage

// [logic/rbp_port.sv]
// Asynchronous byte-wide host register port with sixteen register locations
// Function
// - Write only while chip select and write enable are both low together.
// - Write begins at the later falling edge of chip select or write enable.
// - Write ends at first rising edge; data from the last sample before it is latched.
// - Data pins float whenever output enable is high, writes included.
// - Chip select falling with or after write enable: outputs never drive.
// - Write enable qualifies register writes only together with chip select low.
// - Sixteen byte-wide registers selected by the address inputs.
`timescale 1ns/1ps
`default_nettype none
module rbp_port
  import rbp_pkg::*;
#(
  parameter int unsigned NUM_REGS = RBP_NUM_REGS
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic cs_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [RBP_ADDR_W-1:0] addr,
  input wire logic [RBP_DATA_W-1:0] dq_in,
  output logic [RBP_DATA_W-1:0] dq_out,
  output logic dq_oe_n,
  output logic wr_strobe,
  output logic [RBP_ADDR_W-1:0] wr_addr,
  output logic [RBP_DATA_W-1:0] wr_data
);

  // ==========================================================
  // Input synchronisers
  rbp_bus_t meta;
  rbp_bus_t sync;
  rbp_bus_t held;
  rbp_bus_t pin_bus;

  assign pin_bus = '{cs_n: cs_n, oe_n: oe_n, we_n: we_n, addr: addr, data: dq_in};

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, data: '0};
      sync <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, data: '0};
    end else if (clk_en) begin
      meta <= pin_bus;
      sync <= meta;
    end
  end

  // Previous sample, used only for the end-of-write data
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      held <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, data: '0};
    end else if (clk_en) begin
      held <= sync;
    end
  end

  // ==========================================================
  // Access phase
  rbp_state_t state;
  rbp_state_t next_state;
  logic overlap;

  assign overlap = !sync.cs_n && !sync.we_n;

  always_comb begin
    next_state = state;
    unique case (state)
      RBP_IDLE: begin
        if (!sync.cs_n) begin
          // Select arriving with write enable already low blocks output
          if (!sync.we_n) begin
            next_state = RBP_WRITE;
          end else begin
            next_state = RBP_READ;
          end
        end
      end
      RBP_READ: begin
        if (sync.cs_n) begin
          next_state = RBP_IDLE;
        end else if (!sync.we_n) begin
          next_state = RBP_WRITE;
        end
      end
      RBP_WRITE: begin
        if (sync.cs_n) begin
          next_state = RBP_IDLE;
        end else if (sync.we_n) begin
          next_state = RBP_BLOCKED;
        end
      end
      RBP_BLOCKED: begin
        if (sync.cs_n) begin
          next_state = RBP_IDLE;
        end else if (!sync.we_n) begin
          next_state = RBP_WRITE;
        end
      end
    endcase
  end

  // Tracks whether this select began inside a write-enable low
  logic late_select;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      late_select <= 1'b0;
    end else if (clk_en) begin
      if (sync.cs_n) begin
        late_select <= 1'b0;
      end else if (state == RBP_IDLE && !sync.we_n) begin
        late_select <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= RBP_IDLE;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  // ==========================================================
  // Register storage and write commit
  logic [RBP_DATA_W-1:0] regs [NUM_REGS];
  logic [RBP_ADDR_W-1:0] wr_addr_lat;
  logic write_end;

  assign write_end = state == RBP_WRITE && !overlap;

  // Address taken while the overlap stands
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_addr_lat <= '0;
    end else if (clk_en && overlap) begin
      wr_addr_lat <= sync.addr;
    end
  end

  // Data latched from the last sample inside the overlap
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < int'(NUM_REGS); i++) begin
        regs[i] <= RBP_REG_RESET;
      end
    end else if (clk_en && write_end) begin
      regs[wr_addr_lat] <= held.data;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_strobe <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
    end else if (clk_en) begin
      wr_strobe <= write_end;
      if (write_end) begin
        wr_addr <= wr_addr_lat;
        wr_data <= held.data;
      end
    end
  end

  // ==========================================================
  // Read drive
  logic drive;

  assign drive = !sync.cs_n && !sync.oe_n && sync.we_n && !late_select
      && !(state == RBP_IDLE && !sync.we_n);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dq_oe_n <= 1'b1;
      dq_out <= '0;
    end else if (clk_en) begin
      dq_oe_n <= !drive;
      dq_out <= regs[sync.addr];
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  float_on_oe_a: assert property (clk_en && sync.oe_n |=> dq_oe_n)
    else $error("data pins driven with output enable high");
  no_drive_write_a: assert property (clk_en && !sync.we_n |=> dq_oe_n)
    else $error("data pins driven during write enable low");
  float_deselect_a: assert property (clk_en && sync.cs_n |=> dq_oe_n)
    else $error("data pins driven while deselected");
  late_select_a: assert property (late_select && !sync.cs_n |=> dq_oe_n)
    else $error("output driven after late select");
  write_needs_overlap_a: assert property (wr_strobe |-> $past(state == RBP_WRITE))
    else $error("write without overlap");
  write_start_a: assert property (clk_en && state == RBP_IDLE && overlap
      |=> state == RBP_WRITE)
    else $error("write start missed");
  write_end_a: assert property (clk_en && state == RBP_WRITE && (sync.cs_n || sync.we_n)
      |=> wr_strobe)
    else $error("write end missed");
  write_data_a: assert property (clk_en && write_end |=> wr_data == $past(held.data))
    else $error("latched data differs from end-of-write data");
  store_a: assert property (wr_strobe && clk_en |-> regs[wr_addr] == wr_data)
    else $error("register not updated");
  no_write_we_high_a: assert property (clk_en && sync.we_n && state != RBP_WRITE
      |=> !wr_strobe)
    else $error("write without write enable");

  read_cov_c: cover property (!dq_oe_n);
  write_cov_c: cover property (wr_strobe);
  late_cov_c: cover property (late_select ##1 wr_strobe);
  blocked_cov_c: cover property (state == RBP_BLOCKED);

endmodule
`default_nettype wire

// [sim/rbp_host.sv]
// Host bus model driving the port strobes
`timescale 1ns/1ps
`default_nettype none
module rbp_host
  import rbp_pkg::*;
(
  input wire logic core_clk,
  output logic cs_n,
  output logic oe_n,
  output logic we_n,
  output logic [3:0] addr,
  output logic [7:0] dq_in
);
  initial {cs_n, oe_n, we_n, addr, dq_in} = 15'h7000;
  task automatic drive(input logic [2:0] s, input int n);
    {cs_n, oe_n, we_n} = s;
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Mode 0 ends on we_n, 1 on cs_n, 2 selects late with oe_n low
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] m);
    {addr, dq_in} = {a, d};
    drive(m[1] ? 3'b100 : 3'b011, 3);
    drive(m[1] ? 3'b000 : 3'b010, 4);
    drive(m == 2'd0 ? 3'b011 : m[0] ? 3'b110 : 3'b001, 3);
    dq_in = ~d;
    drive(3'b111, 4);
  endtask
  task automatic rd(input logic [3:0] a);
    addr = a;
    dq_in = ~dq_in;
    drive(3'b001, 4);
  endtask
endmodule
`default_nettype wire

// [sim/rbp_port_bench.sv]
// Self-checking bench for the register port
`timescale 1ns/1ps
`default_nettype none
module rbp_port_bench
  import rbp_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic cs_n, oe_n, we_n, dq_oe_n, wr_strobe;
  logic [3:0] addr, wr_addr;
  logic [7:0] dq_in, dq_out, wr_data;
  logic [7:0] exp_reg [16];
  int n_fail = 0, compares = 0, n_wr = 0, n_drv = 0, w, d;
  initial forever #50 core_clk = ~core_clk;
  rbp_host host (.core_clk, .cs_n, .oe_n, .we_n, .addr, .dq_in);
  rbp_port dut (.core_clk, .rst_n, .clk_en, .cs_n, .oe_n, .we_n, .addr, .dq_in,
    .dq_out, .dq_oe_n, .wr_strobe, .wr_addr, .wr_data);
  always @(posedge core_clk) begin
    n_wr += int'(wr_strobe === 1'b1);
    n_drv += int'(dq_oe_n === 1'b0);
  end
  task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] want);
    compares++;
    if (seen !== want) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic print_verdict();
    if (n_fail == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic t_wr();
    d = n_drv;
    for (int i = 0; i < 16; i++) begin
      w = n_wr;
      exp_reg[i] = {i[3:0], ~i[3:0]};
      host.wr(i[3:0], exp_reg[i], {1'b0, i[0]});
      chk("wr count", 12'(n_wr - w), 12'h001);
      chk("wr addr data", {wr_addr, wr_data}, {i[3:0], exp_reg[i]});
    end
    chk("drive in write", 12'(n_drv - d), 12'h000);
  endtask
  task automatic t_lone();
    w = n_wr;
    d = n_drv;
    host.drive(3'b110, 5);
    host.drive(3'b011, 5);
    host.drive(3'b101, 5);
    host.drive(3'b111, 4);
    chk("lone wr", 12'(n_wr - w), 12'h000);
    chk("lone drive", 12'(n_drv - d), 12'h000);
  endtask
  task automatic t_late();
    w = n_wr;
    d = n_drv;
    exp_reg[3] = 8'h5A;
    host.wr(4'h3, 8'h5A, 2'd2);
    chk("late drive", 12'(n_drv - d), 12'h000);
    chk("late wr", {4'(n_wr - w), wr_data}, 12'h15A);
  endtask
  // Write attempt while the clock enable is low must leave no trace
  task automatic t_freeze();
    w = n_wr;
    clk_en = 1'b0;
    host.wr(4'h5, 8'hC3, 2'd0);
    clk_en = 1'b1;
    host.drive(3'b111, 3);
    chk("frozen wr", 12'(n_wr - w), 12'h000);
  endtask
  task automatic t_rd();
    for (int i = 0; i < 16; i++) begin
      host.rd(i[3:0]);
      chk("read", {3'h0, dq_oe_n, dq_out}, {4'h0, exp_reg[i]});
      host.drive(3'b111, 4);
      chk("idle float", {11'h000, dq_oe_n}, 12'h001);
    end
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    #1;
    chk("reset state", {3'h0, dq_oe_n, dq_out}, 12'h100);
    rst_n = 1'b1;
    host.drive(3'b111, 3);
    t_wr();
    t_lone();
    t_late();
    t_freeze();
    t_rd();
    print_verdict();
  end
  initial begin
    #200000;
    n_fail++;
    print_verdict();
  end
endmodule
`default_nettype wire
